// [hw/rsx_exec.sv]
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rsx_exec
  import rsx_pkg::*;
#(
  parameter int ADDR_W = RSX_ADDR_W,
  parameter int DATA_W = RSX_DATA_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [RSX_INSTR_W-1:0] instr,
  input  wire logic                   instr_valid,
  input  wire logic                   wake_up,
  output logic      [ADDR_W-1:0]      file_addr,
  output logic                        file_rd,
  input  wire logic [DATA_W-1:0]      file_rdata,
  output logic                        file_wr,
  output logic      [DATA_W-1:0]      file_wdata,
  output logic      [DATA_W-1:0]      w_value,
  output logic                        carry_flag,
  output logic                        time_out_flag,
  output logic                        power_down_flag,
  output logic                        watchdog_clear,
  output logic                        prescaler_clear,
  output logic                        osc_run,
  output logic      [1:0]             phase
);
  initial begin
    if (ADDR_W != RSX_ADDR_W) $error("rsx_exec: ADDR_W must match encoding");
    if (DATA_W != RSX_DATA_W) $error("rsx_exec: DATA_W must be 8");
    if (RSX_OP_MSB - RSX_OP_LSB + 1 != 6) $error("rsx_exec: opcode field must be 6 bits");
    if (ADDR_W > RSX_DEST_BIT) $error("rsx_exec: address overlaps destination bit");
    if (RSX_INSTR_W <= RSX_OP_MSB) $error("rsx_exec: opcode outside instruction word");
    if (DATA_W < 2) $error("rsx_exec: DATA_W too small for rotate");
  end

  rsx_phase_t                 phase_reg, phase_next;
  logic [RSX_INSTR_W-1:0]     ir_reg;
  logic                       ir_valid_reg;
  logic [DATA_W-1:0]          operand_reg;
  logic [DATA_W-1:0]          result_reg;
  logic                       carry_new_reg;
  logic [DATA_W-1:0]          w_reg;
  logic                       carry_reg;
  logic                       to_reg;
  logic                       pd_reg;
  logic                       sleep_reg;
  logic                       wdt_clr_reg;

  // wake-up synchroniser
  logic                       wake_meta_reg;
  logic                       wake_sync_reg;

  // decode of the latched instruction
  wire [5:0] op_field    = ir_reg[RSX_OP_MSB:RSX_OP_LSB];
  wire       is_rlc      = ir_valid_reg && (op_field == RSX_OP_RLC);
  wire       is_rrc      = ir_valid_reg && (op_field == RSX_OP_RRC);
  wire       is_rotate   = is_rlc || is_rrc;
  wire       dest_file   = ir_reg[RSX_DEST_BIT] != RSX_DEST_W;
  wire       is_sleep    = ir_valid_reg &&
                           (ir_reg == {RSX_SLEEP_UPPER, RSX_SLEEP_LOWER});
  wire [DATA_W-1:0] rot_result;
  wire              rot_carry;

  // phase strobes
  wire       at_q1       = phase_reg == RSX_Q1;
  wire       at_q2       = phase_reg == RSX_Q2;
  wire       at_q3       = phase_reg == RSX_Q3;
  wire       at_q4       = phase_reg == RSX_Q4;
  wire       write_q4    = at_q4 && is_rotate;
  wire       read_q2     = at_q2 && is_rotate;
  wire       calc_q3     = at_q3 && is_rotate;
  wire       write_w_q4  = write_q4 && !dest_file;
  wire       sleep_exec  = at_q4 && is_sleep && !sleep_reg;
  wire       wake_now    = sleep_reg && wake_sync_reg;

  // rotate datapath
  rsx_rotate_unit #(
    .DATA_W (DATA_W)
  ) rsx_rotate_unit_i (
    .dir_left  (is_rlc),
    .operand   (operand_reg),
    .carry_in  (carry_reg),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // quarter-cycle sequencer, frozen while asleep
  always_comb begin
    case (phase_reg)
      RSX_Q1:  phase_next = RSX_Q2;
      RSX_Q2:  phase_next = RSX_Q3;
      RSX_Q3:  phase_next = RSX_Q4;
      RSX_Q4:  phase_next = RSX_Q1;
      default: phase_next = RSX_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake_up;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= RSX_Q1;
    end else if (!sleep_reg) begin
      phase_reg <= phase_next;
    end
  end

  // q1 decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg       <= '0;
      ir_valid_reg <= 1'b0;
    end else if (at_q1 && !sleep_reg) begin
      ir_reg       <= instr;
      ir_valid_reg <= instr_valid;
    end
  end

  // q2 read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_reg <= '0;
    end else if (read_q2) begin
      operand_reg <= file_rdata;
    end
  end

  // q3 compute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg    <= '0;
      carry_new_reg <= RSX_CARRY_RESET;
    end else if (calc_q3) begin
      result_reg    <= rot_result;
      carry_new_reg <= rot_carry;
    end
  end

  // q4 carry update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_reg <= RSX_CARRY_RESET;
    end else if (write_q4) begin
      carry_reg <= carry_new_reg;
    end
  end

  // q4 working register update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= RSX_W_RESET;
    end else if (write_w_q4) begin
      w_reg <= result_reg;
    end
  end

  // power-down status flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_reg <= RSX_TO_RESET;
      pd_reg <= RSX_PD_RESET;
    end else if (sleep_exec) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b0;
    end
  end

  // watchdog and prescaler clear pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_clr_reg <= 1'b0;
    end else begin
      wdt_clr_reg <= sleep_exec;
    end
  end

  // sleep state, left on synchronised wake-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_reg <= 1'b0;
    end else if (sleep_exec) begin
      sleep_reg <= 1'b1;
    end else if (wake_now) begin
      sleep_reg <= 1'b0;
    end
  end

  // file register port
  assign file_addr       = ir_reg[ADDR_W-1:0];
  assign file_rd         = at_q2 && is_rotate && !sleep_reg;
  assign file_wr         = write_q4 && dest_file && !sleep_reg;
  assign file_wdata      = result_reg;

  // working register and status
  assign w_value         = w_reg;
  assign carry_flag      = carry_reg;
  assign time_out_flag   = to_reg;
  assign power_down_flag = pd_reg;

  // power control
  assign watchdog_clear  = wdt_clr_reg;
  assign prescaler_clear = wdt_clr_reg;
  assign osc_run         = !sleep_reg;
  assign phase           = phase_reg;
endmodule // rsx_exec

// [hw/rsx_pkg.sv]
package rsx_pkg;
  localparam int          RSX_INSTR_W     = 14;
  localparam int          RSX_DATA_W      = 8;
  localparam int          RSX_ADDR_W      = 7;
  localparam logic [5:0]  RSX_OP_RLC      = 6'h0d;
  localparam logic [5:0]  RSX_OP_RRC      = 6'h0c;
  localparam int          RSX_OP_MSB      = 13;
  localparam int          RSX_OP_LSB      = 8;
  localparam int          RSX_DEST_BIT    = 7;
  localparam logic [9:0]  RSX_SLEEP_UPPER = 10'h006;
  localparam logic [3:0]  RSX_SLEEP_LOWER = 4'h3;
  localparam int          RSX_SLEEP_SHIFT = 4;
  localparam logic [7:0]  RSX_WDT_CLEAR   = 8'h00;
  localparam logic        RSX_DEST_W      = 1'b0;
  localparam logic        RSX_TO_RESET    = 1'b1;
  localparam logic        RSX_PD_RESET    = 1'b1;
  localparam logic        RSX_CARRY_RESET = 1'b0;
  localparam logic [7:0]  RSX_W_RESET     = 8'h00;
  typedef enum logic [1:0] {
    RSX_Q1,
    RSX_Q2,
    RSX_Q3,
    RSX_Q4
  } rsx_phase_t;
endpackage

// [hw/rsx_rotate_unit.sv]
`timescale 1ns/1ps
module rsx_rotate_unit
  import rsx_pkg::*;
#(
  parameter int DATA_W = RSX_DATA_W
) (
  input  wire logic              dir_left,
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  output logic      [DATA_W-1:0] result,
  output logic                   carry_out
);
  initial begin
    if (DATA_W < 2) $error("rsx_rotate_unit: DATA_W too small");
  end
  wire [DATA_W-1:0] left_val  = {operand[DATA_W-2:0], carry_in};
  wire [DATA_W-1:0] right_val = {carry_in, operand[DATA_W-1:1]};
  assign result    = dir_left ? left_val : right_val;
  assign carry_out = dir_left ? operand[DATA_W-1] : operand[0];
endmodule // rsx_rotate_unit

// [test/rsx_exec_bench.sv]
`timescale 1ns/1ps
module rsx_exec_bench;
  import rsx_pkg::*;
  logic        clk = 0, rst_n = 0, instr_valid = 0, wake_up = 0, ec = 0;
  logic        file_rd, file_wr, carry_flag, time_out_flag, power_down_flag;
  logic        watchdog_clear, prescaler_clear, osc_run;
  logic [13:0] instr = '0;
  logic [7:0]  file_rdata = '0, ew = '0, file_wdata, w_value;
  logic [6:0]  file_addr;
  logic [1:0]  phase;
  int          err_count = 0, checked = 0, cyc = 0;
  always #4 clk = ~clk;
  rsx_exec rsx_exec_i (.clk, .rst_n, .instr, .instr_valid, .wake_up, .file_addr, .file_rd,
    .file_rdata, .file_wr, .file_wdata, .w_value, .carry_flag, .time_out_flag,
    .power_down_flag, .watchdog_clear, .prescaler_clear, .osc_run, .phase);
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_count++;
      stop_test;
    end
  end
  task issue(input logic [13:0] i, input logic v, input logic [7:0] d);
    do @(negedge clk); while (phase !== 2'h3);
    @(posedge clk);
    instr <= i;
    instr_valid <= v;
    file_rdata <= d;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  task rot(input logic l, input logic dd, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    r = l ? {d[6:0], ec} : {ec, d[7:1]};
    issue({l ? RSX_OP_RLC : RSX_OP_RRC, dd, a}, 1'b1, d);
    #1 chk(file_addr, a);
    chk(file_rd, 1'b1);
    chk(phase, 2'h1);
    repeat (2) @(posedge clk);
    #1 chk(file_wr, dd);
    if (dd) chk(file_wdata, r);
    if (!dd) ew = r;
    ec = l ? d[7] : d[0];
    @(posedge clk);
    #1 chk(w_value, ew);
    chk(carry_flag, ec);
  endtask
  task t_rot;
    rot(1'b0, 1'b0, 7'h05, 8'he6);
    rot(1'b1, 1'b0, 7'h05, 8'he6);
    rot(1'b1, 1'b1, 7'h7f, 8'h01);
    rot(1'b0, 1'b1, 7'h00, 8'h01);
    rot(1'b0, 1'b0, 7'h2a, 8'h00);
    $display("rotate test done");
  endtask
  task t_ign;
    issue(14'h0062, 1'b1, 8'h00);
    #1 chk(file_rd, 1'b0);
    issue({RSX_OP_RLC, 8'h85}, 1'b0, 8'hff);
    #1 chk(file_rd, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(osc_run, 1'b1);
    chk(w_value, ew);
    chk(carry_flag, ec);
    $display("ignore test done");
  endtask
  task t_slp;
    issue(14'h0063, 1'b1, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({time_out_flag, power_down_flag, osc_run}, 3'b100);
    chk({watchdog_clear, prescaler_clear}, 2'b11);
    @(posedge clk);
    instr <= {RSX_OP_RLC, 8'h85};
    instr_valid <= 1'b1;
    repeat (8) @(posedge clk);
    instr_valid <= 1'b0;
    wake_up <= 1'b1;
    #1 chk({file_rd, osc_run, watchdog_clear, carry_flag}, {3'b000, ec});
    repeat (4) @(posedge clk);
    wake_up <= 1'b0;
    #1 chk(osc_run, 1'b1);
    rot(1'b1, 1'b1, 7'h11, 8'h80);
    $display("sleep test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_rot;
    t_ign;
    t_slp;
    stop_test;
  end
endmodule // rsx_exec_bench

// [test/rsx_exec_monitor.sv]
`timescale 1ns/1ps
module rsx_exec_monitor
  import rsx_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  file_rd,
  input wire logic                  file_wr,
  input wire logic [RSX_DATA_W-1:0] w_value,
  input wire logic                  carry_flag,
  input wire logic                  time_out_flag,
  input wire logic                  power_down_flag,
  input wire logic                  watchdog_clear,
  input wire logic                  prescaler_clear,
  input wire logic                  osc_run,
  input wire logic [1:0]            phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_clr;
    watchdog_clear && prescaler_clear && !osc_run ##1 !watchdog_clear;
  endsequence
  property p_rd; file_rd |-> phase == 2'h1; endproperty
  property p_wr; file_wr |-> phase == 2'h3; endproperty
  property p_clr; $fell(osc_run) |-> s_clr; endproperty
  property p_flg; $fell(osc_run) |-> time_out_flag && !power_down_flag; endproperty
  property p_pd; $fell(power_down_flag) |-> $fell(osc_run); endproperty
  property p_c; $changed(carry_flag) |-> $past(phase) == 2'h3; endproperty
  property p_w; $changed(w_value) |-> $past(phase) == 2'h3 && !$past(file_wr); endproperty
  property p_hlt; !osc_run && !$past(osc_run) |-> $stable(phase) && !file_rd; endproperty
  a_rd: assert property (p_rd) else $error("read phase");
  a_wr: assert property (p_wr) else $error("write phase");
  a_clr: assert property (p_clr) else $error("clear pulse");
  a_flg: assert property (p_flg) else $error("sleep flags");
  a_pd: assert property (p_pd) else $error("flag source");
  a_c: assert property (p_c) else $error("carry timing");
  a_w: assert property (p_w) else $error("w timing");
  a_hlt: assert property (p_hlt) else $error("not halted");
endmodule // rsx_exec_monitor
bind rsx_exec rsx_exec_monitor rsx_exec_monitor_i (.clk, .rst_n, .file_rd, .file_wr, .w_value,
  .carry_flag, .time_out_flag, .power_down_flag, .watchdog_clear, .prescaler_clear,
  .osc_run, .phase);
